//--- rgs_map.svh
`ifndef RGS_MAP_SVH
`define RGS_MAP_SVH
// Register byte offsets on the Wishbone slave.
`define RGS_ADR_GAIN_CFG 8'h00
`define RGS_ADR_CTRL 8'h04
`define RGS_ADR_GAIN_STATE 8'h08
`define RGS_ADR_STRENGTH 8'h0c
`define RGS_ADR_CMD 8'h10
// Command register bit positions; writing a one issues the command.
`define RGS_CMD_GAIN_RESET 0
`define RGS_CMD_SQUELCH 1
`define RGS_CMD_STRENGTH_CLEAR 2
`define RGS_CMD_ANALOG_PRESET 3
// Field widths and positions.
`define RGS_CODE_W 4
`define RGS_CTRL_W 13
`define RGS_STRENGTH_B_LSB 4
// Reset values.
`define RGS_CTRL_RESET 13'h0005
`define RGS_GAIN_CFG_RESET 4'h0
// Gain code layout.
`define RGS_CODE_MAX 4'ha
`define RGS_CODE_PRESET 4'h4
`define RGS_CODE_ZERO 4'h0
`define RGS_WIN_MAX 3'h4
`define RGS_RED_NONE 3'h0
`define RGS_PEER_RED 3'h2
`define RGS_PEER_FILTER 6'h05
`define RGS_STRENGTH_MAX 4'hd
// Loop figures.
`define RGS_SQ_TOGGLE_LIMIT 2
`define RGS_AGC_PULSES 8
// Timing: clock period and times in nanoseconds.
`define RGS_CLK_NS 40
`define RGS_SQ_DELAY_NS 18880
`define RGS_SQ_WINDOW_NS 50000
`endif

//--- rgs_pkg.sv
package rgs_pkg;
  // Squelch sequencer states.
  typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_RUN} rgs_sq_e;
  // Software control bits, most significant field first.
  typedef struct packed {
    logic [5:0] filter;
    logic peer_mode;
    logic peer_gain_force;
    logic clip_en;
    logic sqm_dyn;
    logic agc_alg;
    logic agc_mode;
    logic agc_en;
  } rgs_ctrl_s;
endpackage

//--- rgs_toggle_window.sv
`timescale 1ns/1ps
module rgs_toggle_window #(
  parameter int WIN_CYC = 1250,
  parameter int LIMIT = 2
) (
  input wire logic clk_i,  // System clock.
  input wire logic rst_i,  // Synchronous reset.
  input wire logic run_i,  // Observation enabled.
  input wire logic din_i,  // Observed comparator output.
  output logic done_o,     // One-cycle pulse at window end.
  output logic over_o      // With done_o: more than LIMIT toggles seen.
);
  logic d_q;
  logic [$clog2(WIN_CYC)-1:0] win_cnt;
  logic [$clog2(LIMIT+2)-1:0] tog_cnt;
  logic win_end;

  // Window end is reached on the last cycle of the count.
  assign win_end = run_i && (win_cnt == ($clog2(WIN_CYC))'(WIN_CYC - 1));

  // Previous input for edge detection.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      d_q <= 1'b0;
    end else begin
      d_q <= din_i;
    end
  end

  // Window timer and saturating toggle count.
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i || win_end) begin
      win_cnt <= '0;
      tog_cnt <= '0;
    end else begin
      win_cnt <= win_cnt + 1'b1;
      if ((din_i != d_q) && (tog_cnt <= ($clog2(LIMIT+2))'(LIMIT))) begin
        tog_cnt <= tog_cnt + 1'b1;
      end
    end
  end

  // Verdict pulse for the window just closed.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      over_o <= 1'b0;
    end else begin
      done_o <= win_end;
      over_o <= win_end && (tog_cnt > ($clog2(LIMIT+2))'(LIMIT));
    end
  end
endmodule

//--- rgs_peak_hold.sv
`timescale 1ns/1ps
module rgs_peak_hold #(
  parameter int W = 4,
  parameter logic [W-1:0] MAX = 4'hd
) (
  input wire logic clk_i,          // System clock.
  input wire logic rst_i,          // Synchronous reset.
  input wire logic clr_i,          // Restart from zero.
  input wire logic track_i,        // Follow the input while high.
  input wire logic [W-1:0] level_i,  // Present strength level.
  output logic [W-1:0] value_o     // Held peak.
);
  logic [W-1:0] lim;

  // Levels above the top code are clipped to it.
  assign lim = (level_i > MAX) ? MAX : level_i;

  // Peak hold: only rises while tracking, frozen otherwise.
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      value_o <= '0;
    end else if (track_i && (lim > value_o)) begin
      value_o <= lim;
    end
  end
endmodule

//--- rgs_gain_ctrl.sv
// Functional notes
// - Digitizer window has five 3 dB steps, from loop state or manual setting.
// - Eleven gain codes: zero minimum window, four widen window, six cut gain.
// - Squelch starts from the configured initial code; gain control from preset 4h or the squelch code.
// - A readable gain state register shows the resulting gain code.
// - Squelch steps 3 dB up while more than two toggles per 50 us.
// - Squelch accumulated reduction clears only on the gain-reset command.
// - Gain-reset command resets loops and strength, loads shadow from config.
// - Dynamic squelch starts 18.88 us after transmit end, stops on mask expiry.
// - Squelch command is taken only while receive-active is low.
// - Gain control acts from receive-active rise and resets on its fall.
// - Receive-active fall captures gain code into the gain state register.
// - Gain control steps reduction while its wide comparator still toggles.
// - Enable bit switches gain control; mode bit picks whole or first eight pulses.
// - Algorithm bit starts gain control at preset code 4h or at the squelch code.
// - After reset gain control is on, whole period, preset algorithm.
// - Strength of both channels peak-holds from zero while receive-active high.
// - Every gain control step restarts strength measurement from zero.
// - Strength per channel is a 4-bit code, 2.8 dB step, top code Dh.
// - Strength clear command zeroes strength and restarts peak hold.
// - Clipping bit turns on limiters after first and second stages.
// - Peer gain bit forces 6 dB stage reduction with window at maximum.
// - Analog preset loads filter, clipping and peer gain bits once peer mode is set.
`timescale 1ns/1ps
`include "rgs_map.svh"
module rgs_gain_ctrl #(
  parameter int SQ_WIN_CYC = `RGS_SQ_WINDOW_NS / `RGS_CLK_NS,
  parameter int SQ_DLY_CYC = (`RGS_SQ_DELAY_NS + `RGS_CLK_NS - 1) / `RGS_CLK_NS
) (
  input wire logic SYS_CLK_I,          // 25 MHz system clock.
  input wire logic SRST_I,             // Synchronous reset, active high.
  input wire logic CYC_I,              // Wishbone cycle.
  input wire logic STB_I,              // Wishbone strobe.
  input wire logic WE_I,               // Wishbone write enable.
  input wire logic [7:0] ADR_I,        // Wishbone byte address.
  input wire logic [3:0] SEL_I,        // Wishbone byte selects.
  input wire logic [31:0] DAT_I,       // Wishbone write data.
  output logic [31:0] DAT_O,           // Wishbone read data.
  output logic ACK_O,                  // Wishbone acknowledge.
  input wire logic RX_ON_I,            // Receive-active level.
  input wire logic TX_END_I,           // Pulse at end of transmission.
  input wire logic MASK_RX_EXPIRE_I,   // Pulse when mask-receive timer expires.
  input wire logic DIG_I,              // Digitizer comparator output.
  input wire logic AGC_CMP_I,          // Wide gain-control comparator output.
  input wire logic SUBC_PULSE_I,       // Pulse per subcarrier pulse.
  input wire logic [3:0] STRENGTH_A_I, // Channel A strength level.
  input wire logic [3:0] STRENGTH_B_I, // Channel B strength level.
  output logic [2:0] DIG_WIN_O,        // Digitizer window step, 0 to 4.
  output logic [2:0] STAGE23_RED_O,    // Stage 2/3 reduction in 3 dB steps.
  output logic CLIP_EN_O,              // Limiters after stages 1 and 2.
  output logic [5:0] FILTER_SEL_O,     // Filter selection bits.
  output logic SQUELCH_RUN_O           // Squelch observing.
);
  localparam logic [`RGS_CODE_W-1:0] CMAX = `RGS_CODE_MAX;

  rgs_pkg::rgs_ctrl_s ctrl;
  rgs_pkg::rgs_sq_e sq_state;
  logic [`RGS_CODE_W-1:0] gain_cfg, shadow, sq_code, gain_code, gain_state, eff_code;
  logic [3:0] str_a, str_b;
  logic [$clog2(SQ_DLY_CYC+1)-1:0] dly_cnt;
  logic [3:0] pulse_cnt;
  logic wb_req, wb_wr, cmd_wr;
  logic cmd_gain_reset, cmd_squelch, cmd_str_clear, cmd_preset;
  logic rx_q, rx_rise, rx_fall, agc_q, agc_active, agc_step;
  logic sq_done, sq_over, str_clr;

  // Saturating one-step increase of a gain code.
  function automatic logic [`RGS_CODE_W-1:0] sat_inc(input logic [`RGS_CODE_W-1:0] c);
    sat_inc = (c >= CMAX) ? CMAX : c + 1'b1;
  endfunction

  // Window step for a gain code: the first four steps widen the window.
  function automatic logic [2:0] win_of(input logic [`RGS_CODE_W-1:0] c);
    win_of = (c >= 4'(`RGS_WIN_MAX)) ? `RGS_WIN_MAX : c[2:0];
  endfunction

  // Stage reduction for a gain code: steps beyond the window cut gain.
  function automatic logic [2:0] red_of(input logic [`RGS_CODE_W-1:0] c);
    red_of = (c > 4'(`RGS_WIN_MAX)) ? 3'(c - 4'(`RGS_WIN_MAX)) : `RGS_RED_NONE;
  endfunction

  // Bus decode; commands are one-cycle pulses from a write to the command word.
  assign wb_req = CYC_I && STB_I && !ACK_O;
  assign wb_wr = wb_req && WE_I && SEL_I[0];
  assign cmd_wr = wb_wr && (ADR_I == `RGS_ADR_CMD);
  assign cmd_gain_reset = cmd_wr && DAT_I[`RGS_CMD_GAIN_RESET];
  assign cmd_squelch = cmd_wr && DAT_I[`RGS_CMD_SQUELCH];
  assign cmd_str_clear = cmd_wr && DAT_I[`RGS_CMD_STRENGTH_CLEAR];
  assign cmd_preset = cmd_wr && DAT_I[`RGS_CMD_ANALOG_PRESET];

  // Receive-active edges and gain-control comparator toggles.
  assign rx_rise = RX_ON_I && !rx_q;
  assign rx_fall = !RX_ON_I && rx_q;
  assign agc_active = ctrl.agc_en && RX_ON_I && rx_q &&
    (!ctrl.agc_mode || (pulse_cnt < 4'(`RGS_AGC_PULSES)));
  assign agc_step = agc_active && (AGC_CMP_I != agc_q) && (gain_code < CMAX);

  // Wishbone acknowledge: one cycle after the request, dropped the next.
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      ACK_O <= 1'b0;
    end else begin
      ACK_O <= wb_req;
    end
  end

  // Read data; unmapped offsets read zero.
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      DAT_O <= '0;
    end else if (wb_req && !WE_I) begin
      case (ADR_I)
        `RGS_ADR_GAIN_CFG: DAT_O <= 32'(gain_cfg);
        `RGS_ADR_CTRL: DAT_O <= 32'(ctrl);
        `RGS_ADR_GAIN_STATE: DAT_O <= 32'(gain_state);
        `RGS_ADR_STRENGTH: DAT_O <= 32'({str_b, str_a});
        default: DAT_O <= '0;
      endcase
    end
  end

  // Manual gain configuration word.
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      gain_cfg <= `RGS_GAIN_CFG_RESET;
    end else if (wb_wr && (ADR_I == `RGS_ADR_GAIN_CFG)) begin
      gain_cfg <= (DAT_I[3:0] > CMAX) ? CMAX : DAT_I[3:0];
    end
  end

  // Control word; the analog preset loads the peer settings when peer mode is set.
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      ctrl <= `RGS_CTRL_RESET;
    end else if (wb_wr && (ADR_I == `RGS_ADR_CTRL)) begin
      ctrl <= DAT_I[`RGS_CTRL_W-1:0];
    end else if (cmd_preset && ctrl.peer_mode) begin
      ctrl.filter <= `RGS_PEER_FILTER;
      ctrl.clip_en <= 1'b1;
      ctrl.peer_gain_force <= 1'b1;
    end
  end

  // Edge history of receive-active and the wide comparator.
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      rx_q <= 1'b0;
      agc_q <= 1'b0;
    end else begin
      rx_q <= RX_ON_I;
      agc_q <= AGC_CMP_I;
    end
  end

  // Subcarrier pulses counted from the start of reception.
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I || !RX_ON_I) begin
      pulse_cnt <= '0;
    end else if (SUBC_PULSE_I && (pulse_cnt < 4'(`RGS_AGC_PULSES))) begin
      pulse_cnt <= pulse_cnt + 1'b1;
    end
  end

  // Squelch sequencer: dynamic start after transmit or command while receive is off.
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I || cmd_gain_reset) begin
      sq_state <= rgs_pkg::SQ_IDLE;
      dly_cnt <= '0;
    end else begin
      case (sq_state)
        rgs_pkg::SQ_IDLE: begin
          if (ctrl.sqm_dyn && TX_END_I) begin
            sq_state <= rgs_pkg::SQ_WAIT;
            dly_cnt <= ($clog2(SQ_DLY_CYC+1))'(SQ_DLY_CYC - 1);
          end else if (cmd_squelch && !RX_ON_I) begin
            sq_state <= rgs_pkg::SQ_RUN;
          end
        end
        rgs_pkg::SQ_WAIT: begin
          if (MASK_RX_EXPIRE_I) begin
            sq_state <= rgs_pkg::SQ_IDLE;
          end else if (dly_cnt == '0) begin
            sq_state <= rgs_pkg::SQ_RUN;
          end else begin
            dly_cnt <= dly_cnt - 1'b1;
          end
        end
        rgs_pkg::SQ_RUN: begin
          if (MASK_RX_EXPIRE_I && ctrl.sqm_dyn) begin
            sq_state <= rgs_pkg::SQ_IDLE;
          end else if (sq_done && (!sq_over || sq_code == CMAX) && !ctrl.sqm_dyn) begin
            sq_state <= rgs_pkg::SQ_IDLE;
          end
        end
        default: sq_state <= rgs_pkg::SQ_IDLE;
      endcase
    end
  end

  // Toggle observation of the digitizer in 50 us windows.
  rgs_toggle_window #(
    .WIN_CYC(SQ_WIN_CYC),
    .LIMIT(`RGS_SQ_TOGGLE_LIMIT)
  ) u_window (
    .clk_i(SYS_CLK_I),
    .rst_i(SRST_I),
    .run_i(sq_state == rgs_pkg::SQ_RUN),
    .din_i(DIG_I),
    .done_o(sq_done),
    .over_o(sq_over)
  );

  // Shadow of the configuration and squelch reduction; only gain reset clears it.
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      shadow <= `RGS_GAIN_CFG_RESET;
      sq_code <= `RGS_GAIN_CFG_RESET;
    end else if (cmd_gain_reset) begin
      shadow <= gain_cfg;
      sq_code <= gain_cfg;
    end else if (sq_done && sq_over && sq_state == rgs_pkg::SQ_RUN) begin
      sq_code <= sat_inc(sq_code);
    end
  end

  // Live gain code shared by squelch and gain control.
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      gain_code <= `RGS_GAIN_CFG_RESET;
    end else if (cmd_gain_reset) begin
      gain_code <= gain_cfg;
    end else if (rx_fall) begin
      gain_code <= sq_code;
    end else if (rx_rise && ctrl.agc_en) begin
      gain_code <= ctrl.agc_alg ? `RGS_CODE_PRESET : sq_code;
    end else if (agc_step) begin
      gain_code <= sat_inc(gain_code);
    end else if (sq_done && sq_over && sq_state == rgs_pkg::SQ_RUN) begin
      gain_code <= sat_inc(sq_code);
    end
  end

  // Readable gain state: last reception's gain, or the squelch result.
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      gain_state <= `RGS_GAIN_CFG_RESET;
    end else if (cmd_gain_reset) begin
      gain_state <= gain_cfg;
    end else if (rx_fall) begin
      gain_state <= gain_code;
    end else if (sq_done && sq_over && sq_state == rgs_pkg::SQ_RUN) begin
      gain_state <= sat_inc(sq_code);
    end
  end

  // Strength restarts on reception start, gain steps, clear and gain reset.
  assign str_clr = rx_rise || agc_step || cmd_str_clear || cmd_gain_reset;

  rgs_peak_hold #(
    .W(4),
    .MAX(`RGS_STRENGTH_MAX)
  ) u_peak_a (
    .clk_i(SYS_CLK_I),
    .rst_i(SRST_I),
    .clr_i(str_clr),
    .track_i(RX_ON_I),
    .level_i(STRENGTH_A_I),
    .value_o(str_a)
  );

  rgs_peak_hold #(
    .W(4),
    .MAX(`RGS_STRENGTH_MAX)
  ) u_peak_b (
    .clk_i(SYS_CLK_I),
    .rst_i(SRST_I),
    .clr_i(str_clr),
    .track_i(RX_ON_I),
    .level_i(STRENGTH_B_I),
    .value_o(str_b)
  );

  // Loop state is used when a loop is enabled or squelch has acted.
  assign eff_code = (ctrl.agc_en || ctrl.sqm_dyn || sq_code != shadow ||
    sq_state != rgs_pkg::SQ_IDLE) ? gain_code : gain_cfg;

  // Registered analog controls.
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      DIG_WIN_O <= '0;
      STAGE23_RED_O <= '0;
      CLIP_EN_O <= 1'b0;
      FILTER_SEL_O <= '0;
      SQUELCH_RUN_O <= 1'b0;
    end else begin
      DIG_WIN_O <= ctrl.peer_gain_force ? `RGS_WIN_MAX : win_of(eff_code);
      STAGE23_RED_O <= ctrl.peer_gain_force ? `RGS_PEER_RED : red_of(eff_code);
      CLIP_EN_O <= ctrl.clip_en;
      FILTER_SEL_O <= ctrl.filter;
      SQUELCH_RUN_O <= (sq_state == rgs_pkg::SQ_RUN);
    end
  end

  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);

  property p_saturate;
    gain_code <= CMAX && sq_code <= CMAX;
  endproperty
  a_saturate: assert property (p_saturate) else $error("gain code above top");

  property p_capture;
    rx_fall && !cmd_gain_reset |=> gain_state == $past(gain_code);
  endproperty
  a_capture: assert property (p_capture) else $error("gain state not captured");

  property p_state_hold;
    !RX_ON_I && !rx_fall && !cmd_gain_reset && !(sq_done && sq_over) |=> $stable(gain_state);
  endproperty
  a_state_hold: assert property (p_state_hold) else $error("gain state moved");

  property p_sq_refused;
    sq_state == rgs_pkg::SQ_IDLE && RX_ON_I && !TX_END_I |=> sq_state == rgs_pkg::SQ_IDLE;
  endproperty
  a_sq_refused: assert property (p_sq_refused) else $error("squelch taken while rx on");

  property p_peer;
    ctrl.peer_gain_force |=> DIG_WIN_O == `RGS_WIN_MAX && STAGE23_RED_O == `RGS_PEER_RED;
  endproperty
  a_peer: assert property (p_peer) else $error("peer gain not forced");

  property p_str_clear;
    cmd_str_clear |=> str_a == '0 && str_b == '0;
  endproperty
  a_str_clear: assert property (p_str_clear) else $error("strength not cleared");

  property p_agc_step;
    agc_step && !cmd_gain_reset && !rx_fall |=> gain_code == $past(gain_code) + 1'b1 && str_a == '0;
  endproperty
  a_agc_step: assert property (p_agc_step) else $error("gain step wrong");

  property p_gain_reset;
    cmd_gain_reset |=> gain_code == $past(gain_cfg) && shadow == $past(gain_cfg)
      && sq_state == rgs_pkg::SQ_IDLE;
  endproperty
  a_gain_reset: assert property (p_gain_reset) else $error("gain reset ignored");

  property p_dyn_start;
    sq_state == rgs_pkg::SQ_WAIT && dly_cnt == '0 && !MASK_RX_EXPIRE_I && !cmd_gain_reset
      |=> sq_state == rgs_pkg::SQ_RUN;
  endproperty
  a_dyn_start: assert property (p_dyn_start) else $error("dynamic squelch late");

  property p_agc_off_rx_low;
    !RX_ON_I |-> !agc_step;
  endproperty
  a_agc_off_rx_low: assert property (p_agc_off_rx_low) else $error("gain control acts off");

  property p_window_map;
    !ctrl.peer_gain_force ##1 !$past(ctrl.peer_gain_force) |-> DIG_WIN_O == win_of($past(eff_code));
  endproperty
  a_window_map: assert property (p_window_map) else $error("window step wrong");
endmodule

//--- rgs_rx_model.sv
`timescale 1ns/1ps
module rgs_rx_model (
  input wire logic clk_i,          // System clock.
  input wire logic noise_i,        // Make the digitizer chatter.
  input wire logic step_i,         // Flip the wide comparator once.
  input wire logic pulse_i,        // Request one subcarrier pulse.
  input wire logic [3:0] lvl_a_i,  // Raw channel A level.
  input wire logic [3:0] lvl_b_i,  // Raw channel B level.
  output logic dig_o,              // Digitizer output.
  output logic agc_cmp_o,          // Wide comparator output.
  output logic subc_o,             // Subcarrier pulse.
  output logic [3:0] str_a_o,      // Channel A strength.
  output logic [3:0] str_b_o       // Channel B strength.
);
  logic ph = 1'b0;
  initial dig_o = 1'b0;
  initial agc_cmp_o = 1'b0;
  initial subc_o = 1'b0;
  // Noise flips the digitizer every second cycle, far above two per window.
  always @(posedge clk_i) begin
    ph <= ~ph;
    if (noise_i && ph) dig_o <= ~dig_o;
    if (step_i) agc_cmp_o <= ~agc_cmp_o;
    subc_o <= pulse_i;
  end
  // The strength detector cannot report above its top code.
  assign str_a_o = (lvl_a_i > 4'hd) ? 4'hd : lvl_a_i;
  assign str_b_o = (lvl_b_i > 4'hd) ? 4'hd : lvl_b_i;
endmodule

//--- rgs_gain_ctrl_bench.sv
`timescale 1ns/1ps
`include "rgs_map.svh"
module rgs_gain_ctrl_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic rx = 1'b0, tx_end = 1'b0, mask_exp = 1'b0;
  logic noise = 1'b0, step = 1'b0, pulse = 1'b0;
  logic [3:0] lvl_a = 4'h0, lvl_b = 4'h0, str_a, str_b;
  logic dig, agc_cmp, subc, run, clip;
  logic [2:0] win, red;
  logic [5:0] filt;
  int miscompares = 0;
  int cmp_count = 0;
  int n;

  // Free-running 25 MHz clock.
  always #20 clk = ~clk;

  rgs_gain_ctrl #(.SQ_WIN_CYC(20), .SQ_DLY_CYC(5)) u_rgs_gain_ctrl (
    .SYS_CLK_I(clk), .SRST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .RX_ON_I(rx), .TX_END_I(tx_end),
    .MASK_RX_EXPIRE_I(mask_exp), .DIG_I(dig), .AGC_CMP_I(agc_cmp), .SUBC_PULSE_I(subc),
    .STRENGTH_A_I(str_a), .STRENGTH_B_I(str_b), .DIG_WIN_O(win), .STAGE23_RED_O(red),
    .CLIP_EN_O(clip), .FILTER_SEL_O(filt), .SQUELCH_RUN_O(run));

  rgs_rx_model u_rgs_rx_model (
    .clk_i(clk), .noise_i(noise), .step_i(step), .pulse_i(pulse), .lvl_a_i(lvl_a),
    .lvl_b_i(lvl_b), .dig_o(dig), .agc_cmp_o(agc_cmp), .subc_o(subc), .str_a_o(str_a),
    .str_b_o(str_b));

  // Prints the counts and the verdict, then stops.
  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task timeout(input string what);
    miscompares++;
    $display("Error %s wait ran out", what);
    end_of_test();
  endtask

  // One classic cycle: hold the request until ack is sampled high.
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) timeout("bus ack");
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  task cmd(input int b);
    wb(1'b1, `RGS_ADR_CMD, 32'h1 << b);
  endtask

  task tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  task wait_run(input logic v);
    for (n = 0; n < 400 && run !== v; n++) @(posedge clk);
    if (run !== v) timeout("squelch run");
  endtask

  // Window and stage reduction expected for a gain code.
  task chk_out(input logic [3:0] c);
    chk("window", (c > 4'h4) ? 32'h4 : {28'h0, c}, {29'h0, win});
    chk("reduction", (c > 4'h4) ? {28'h0, c - 4'h4} : 32'h0, {29'h0, red});
  endtask

  task step_agc;
    @(posedge clk) step <= 1'b1;
    @(posedge clk) step <= 1'b0;
    tick(3);
  endtask

  // Guard against a hang anywhere in the sequence.
  initial begin
    #2000000;
    timeout("run");
  end

  // Main sequence.
  initial begin
    tick(4);
    rst <= 1'b0;
    tick(1);
    rd_chk("ctrl reset", `RGS_ADR_CTRL, 32'h5);
    rd_chk("gain state reset", `RGS_ADR_GAIN_STATE, 32'h0);
    rd_chk("strength reset", `RGS_ADR_STRENGTH, 32'h0);
    rd_chk("unmapped", 8'h14, 32'h0);
    rd_chk("cmd read", `RGS_ADR_CMD, 32'h0);
    wb(1'b1, `RGS_ADR_CTRL, 32'h0);
    for (int c = 0; c < 11; c++) begin
      wb(1'b1, `RGS_ADR_GAIN_CFG, 32'(c));
      tick(3);
      chk_out(c[3:0]);
    end
    wb(1'b1, `RGS_ADR_GAIN_CFG, 32'hf);
    rd_chk("cfg clip", `RGS_ADR_GAIN_CFG, 32'ha);
    sel <= 4'he;
    wb(1'b1, `RGS_ADR_GAIN_CFG, 32'h3);
    sel <= 4'hf;
    rd_chk("masked write", `RGS_ADR_GAIN_CFG, 32'ha);
    // Squelch by command climbs one step per noisy window up to the top.
    wb(1'b1, `RGS_ADR_GAIN_CFG, 32'h2);
    cmd(`RGS_CMD_GAIN_RESET);
    tick(2);
    rd_chk("initial code", `RGS_ADR_GAIN_STATE, 32'h2);
    noise <= 1'b1;
    cmd(`RGS_CMD_SQUELCH);
    for (n = 0; n < 100 && win === 3'h2; n++) @(posedge clk);
    chk_out(4'h3);
    wait_run(1'b0);
    rd_chk("squelch top", `RGS_ADR_GAIN_STATE, 32'ha);
    noise <= 1'b0;
    tick(60);
    rd_chk("squelch kept", `RGS_ADR_GAIN_STATE, 32'ha);
    rx <= 1'b1;
    cmd(`RGS_CMD_SQUELCH);
    tick(3);
    chk("squelch refused", 32'h0, {31'h0, run});
    rx <= 1'b0;
    cmd(`RGS_CMD_GAIN_RESET);
    tick(2);
    rd_chk("squelch cleared", `RGS_ADR_GAIN_STATE, 32'h2);
    // Dynamic squelch after end of transmit.
    wb(1'b1, `RGS_ADR_CTRL, 32'h8);
    @(posedge clk) tx_end <= 1'b1;
    @(posedge clk) tx_end <= 1'b0;
    tick(3);
    chk("dyn early", 32'h0, {31'h0, run});
    wait_run(1'b1);
    @(posedge clk) mask_exp <= 1'b1;
    @(posedge clk) mask_exp <= 1'b0;
    tick(3);
    chk("dyn stop", 32'h0, {31'h0, run});
    // Gain control with preset start and strength peak hold.
    wb(1'b1, `RGS_ADR_GAIN_CFG, 32'h0);
    wb(1'b1, `RGS_ADR_CTRL, 32'h5);
    cmd(`RGS_CMD_GAIN_RESET);
    lvl_a <= 4'h5;
    lvl_b <= 4'h9;
    rx <= 1'b1;
    tick(4);
    chk_out(4'h4);
    rd_chk("strength peak", `RGS_ADR_STRENGTH, 32'h95);
    lvl_a <= 4'h2;
    lvl_b <= 4'h3;
    tick(2);
    rd_chk("strength held", `RGS_ADR_STRENGTH, 32'h95);
    repeat (3) step_agc();
    chk_out(4'h7);
    rd_chk("strength restart", `RGS_ADR_STRENGTH, 32'h32);
    rx <= 1'b0;
    lvl_a <= 4'hf;
    lvl_b <= 4'hf;
    tick(3);
    chk_out(4'h0);
    rd_chk("last rx gain", `RGS_ADR_GAIN_STATE, 32'h7);
    rd_chk("strength frozen", `RGS_ADR_STRENGTH, 32'h32);
    cmd(`RGS_CMD_STRENGTH_CLEAR);
    rd_chk("strength clear", `RGS_ADR_STRENGTH, 32'h0);
    // Squelch-code start, then disabled, then first-eight-pulses mode.
    wb(1'b1, `RGS_ADR_CTRL, 32'h1);
    rx <= 1'b1;
    tick(4);
    chk_out(4'h0);
    step_agc();
    chk_out(4'h1);
    rx <= 1'b0;
    wb(1'b1, `RGS_ADR_CTRL, 32'h0);
    rx <= 1'b1;
    tick(3);
    step_agc();
    chk_out(4'h0);
    rx <= 1'b0;
    wb(1'b1, `RGS_ADR_CTRL, 32'h3);
    rx <= 1'b1;
    tick(3);
    step_agc();
    repeat (8) begin
      @(posedge clk) pulse <= 1'b1;
      @(posedge clk) pulse <= 1'b0;
      tick(1);
    end
    step_agc();
    chk_out(4'h1);
    rx <= 1'b0;
    // Peer mode preset.
    wb(1'b1, `RGS_ADR_CTRL, 32'h40);
    cmd(`RGS_CMD_ANALOG_PRESET);
    tick(3);
    chk("clip", 32'h1, {31'h0, clip});
    chk("filter", 32'h5, {26'h0, filt});
    chk("peer window", 32'h4, {29'h0, win});
    chk("peer reduction", 32'h2, {29'h0, red});
    rd_chk("ctrl preset", `RGS_ADR_CTRL, 32'h2f0);
    end_of_test();
  end
endmodule
